// ### sofc_axil_slave.sv
// sofc_axil_slave.sv: AXI4-Lite slave, one write and one read at a time
// assumes: core decodes rd_addr combinationally and flags unmapped addresses
`timescale 1ns/1ns
`default_nettype none
`include "sofc_regs.svh"
module sofc_axil_slave (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  awvalid,
  output var  logic  awready,
  input  wire logic [31:0] awaddr,
  input  wire logic  wvalid,
  output var  logic  wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic  bvalid,
  input  wire logic  bready,
  output var  logic [1:0]  bresp,
  input  wire logic  arvalid,
  output var  logic  arready,
  input  wire logic [31:0] araddr,
  output var  logic  rvalid,
  input  wire logic  rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  sofc_bus_if.slave  bus
);
  logic aw_have;
  logic aw_page_ok;
  logic w_have;
  logic rd_pend;
  // write channels taken in either order, committed when both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have     <= 1'b0;
      aw_page_ok  <= 1'b0;
      w_have      <= 1'b0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= `SOFC_RESP_OKAY;
      bus.wr_en   <= 1'b0;
      bus.wr_addr <= 8'h00;
      bus.wr_data <= 32'h0000_0000;
      bus.wr_strb <= 4'h0;
    end else begin
      bus.wr_en <= 1'b0;
      if (awvalid && awready) begin
        aw_have     <= 1'b1;
        awready     <= 1'b0;
        // upper bits judged at the take: the master may move awaddr afterwards
        aw_page_ok  <= (awaddr[31:8] == 24'h00_0000);
        bus.wr_addr <= awaddr[7:0];
      end
      if (wvalid && wready) begin
        w_have      <= 1'b1;
        wready      <= 1'b0;
        bus.wr_data <= wdata;
        bus.wr_strb <= wstrb;
      end
      if (aw_have && w_have && !bvalid) begin
        bus.wr_en <= aw_page_ok;
        aw_have   <= 1'b0;
        w_have    <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (bus.wr_ok && aw_page_ok) ? `SOFC_RESP_OKAY : `SOFC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  // read: address latched, data registered one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1; rd_pend <= 1'b0; rvalid <= 1'b0;
      rdata <= 32'h0000_0000; rresp <= `SOFC_RESP_OKAY; bus.rd_addr <= 8'h00;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0; rd_pend <= 1'b1; bus.rd_addr <= araddr[7:0];
      end
      if (rd_pend) begin
        rd_pend <= 1'b0; rvalid <= 1'b1;
        rdata <= bus.rd_ok ? bus.rd_data : 32'h0000_0000;
        rresp <= bus.rd_ok ? `SOFC_RESP_OKAY : `SOFC_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0; arready <= 1'b1;
      end
    end
  end
endmodule : sofc_axil_slave
`default_nettype wire

// ### sofc_bus_if.sv
// sofc_bus_if.sv: register access between bus slave and core
// assumes: one clock, strobes are single-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface sofc_bus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_ok, rd_data, rd_ok);
  modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_ok, rd_data, rd_ok);
endinterface : sofc_bus_if
`default_nettype wire

// ### sofc_core.sv
// sofc_core.sv: safety switching output control with AXI4-Lite registers
// assumes: detection, area and fault inputs are synchronous to aclk
// *****************************************************************
// *****************************************************************
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sofc_regs.svh"
module sofc_core import sofc_pkg::*; #(
  parameter int TW  = 16,
  parameter int AW  = 4,
  parameter int SEQ = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  input  wire logic        zone_hit,
  input  wire logic        mute_area_hit,
  input  wire logic        reset_in,
  input  wire logic        mute_in_a,
  input  wire logic        mute_in_b,
  input  wire logic        override_in,
  input  wire logic [TW-1:0] ref_displacement,
  input  wire logic [AW-1:0] area_sel,
  input  wire logic        ext_fault,
  output var  logic        safety_switch_output,
  output var  logic        muted_out,
  output var  logic        fault_out
);
  // *****************************************************************
  // register access
  // *****************************************************************
  sofc_bus_if bus ();
  sofc_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .bus     (bus.slave)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic wr_hit(input logic [7:0] off);
    return bus.wr_en && (bus.wr_addr == off);
  endfunction : wr_hit

  logic [31:0] ctrl_reg;
  logic [31:0] mint_reg;
  logic [31:0] mmax_reg;
  logic [31:0] ovrp_reg;
  logic [31:0] rtol_reg;
  logic [31:0] stab_reg;
  logic [31:0] trips_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `SOFC_CTRL_RST;
      mint_reg <= `SOFC_MINT_RST;
      mmax_reg <= `SOFC_MMAX_RST;
      ovrp_reg <= `SOFC_OVRP_RST;
      rtol_reg <= `SOFC_RTOL_RST;
      stab_reg <= `SOFC_STAB_RST;
    end else begin
      if (wr_hit(`SOFC_CTRL_OFF)) ctrl_reg <= merge(ctrl_reg, bus.wr_data, bus.wr_strb);
      if (wr_hit(`SOFC_MINT_OFF)) mint_reg <= merge(mint_reg, bus.wr_data, bus.wr_strb);
      if (wr_hit(`SOFC_MMAX_OFF)) mmax_reg <= merge(mmax_reg, bus.wr_data, bus.wr_strb);
      if (wr_hit(`SOFC_OVRP_OFF)) ovrp_reg <= merge(ovrp_reg, bus.wr_data, bus.wr_strb);
      if (wr_hit(`SOFC_RTOL_OFF)) rtol_reg <= merge(rtol_reg, bus.wr_data, bus.wr_strb);
      if (wr_hit(`SOFC_STAB_OFF)) stab_reg <= merge(stab_reg, bus.wr_data, bus.wr_strb);
    end
  end

  // *****************************************************************
  // active configuration
  // *****************************************************************
  // a live copy would let software unlock a running output by rewriting modes
  logic [5:0] cfg_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) cfg_reg <= 6'(`SOFC_CTRL_RST);
    else if (!safety_switch_output) cfg_reg <= ctrl_reg[5:0];
  end
  logic cfg_auto;
  logic cfg_ilock;
  logic cfg_mute;
  logic cfg_ref;
  logic cfg_seq;
  assign cfg_auto  = cfg_reg[`SOFC_CTRL_AUTO];
  assign cfg_ilock = cfg_reg[`SOFC_CTRL_ILOCK];
  assign cfg_mute  = cfg_reg[`SOFC_CTRL_MUTE];
  assign cfg_ref   = cfg_reg[`SOFC_CTRL_REF];
  assign cfg_seq   = cfg_reg[`SOFC_CTRL_SEQ];

  // *****************************************************************
  // time base
  // *****************************************************************
  // one tick per microsecond; all muting limits count these ticks
  localparam int TICK_CYC = `SOFC_TICK_CYC;
  logic [15:0] pre_reg;
  logic        tick_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (pre_reg == 16'(TICK_CYC - 1));
      pre_reg  <= (pre_reg == 16'(TICK_CYC - 1)) ? 16'h0000 : pre_reg + 16'h0001;
    end
  end

  // *****************************************************************
  // muting
  // *****************************************************************
  logic       mu_muted;
  logic       mu_ovr;
  sofc_mute_t mu_state;
  sofc_mute #(.TW(TW)) u_mute (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (tick_reg),
    .enable     (cfg_mute),
    .order_ba   (cfg_reg[`SOFC_CTRL_ORDER]),
    .in_a       (mute_in_a),
    .in_b       (mute_in_b),
    .ovr_req    (override_in),
    .abort      (zone_hit),
    .max_int    (mint_reg[TW-1:0]),
    .max_mute   (mmax_reg[TW-1:0]),
    .ovr_per    (ovrp_reg[TW-1:0]),
    .muted      (mu_muted),
    .ovr_active (mu_ovr),
    .state      (mu_state)
  );

  // *****************************************************************
  // reference boundary and area sequence monitors
  // *****************************************************************
  function automatic logic [TW-1:0] mag(input logic [TW-1:0] v);
    return v[TW-1] ? TW'(~v + 1'b1) : v;
  endfunction : mag

  logic reset_prev_reg;
  logic reset_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) reset_prev_reg <= 1'b0;
    else reset_prev_reg <= reset_in;
  end
  assign reset_edge = reset_in && !reset_prev_reg;

  logic ref_bad;
  logic ref_fault_reg;
  assign ref_bad = cfg_ref && (mag(ref_displacement) > rtol_reg[TW-1:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) ref_fault_reg <= 1'b0;
    else if (ref_bad) ref_fault_reg <= 1'b1;
    else if (reset_edge) ref_fault_reg <= 1'b0;
  end

  function automatic logic [AW-1:0] entry(input logic [31:0] tab,
                                          input logic [1:0]  idx);
    return tab[AW*idx +: AW];
  endfunction : entry

  logic [AW-1:0] area_prev_reg;
  logic [1:0]    seq_idx_reg;
  logic          seq_fault_reg;
  logic          area_chg;
  assign area_chg = (area_sel != area_prev_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      area_prev_reg <= '0;
      seq_idx_reg   <= 2'b00;
      seq_fault_reg <= 1'b0;
    end else begin
      area_prev_reg <= area_sel;
      if (cfg_seq && area_chg) begin
        if (area_sel == entry(stab_reg, 2'(seq_idx_reg + 2'b01)))
          seq_idx_reg <= 2'(seq_idx_reg + 2'b01);
        else seq_fault_reg <= 1'b1;
      end else if (reset_edge && seq_fault_reg) begin
        seq_fault_reg <= 1'b0;
        // re-align the walk on whatever area is selected now
        for (int i = 0; i < SEQ; i++) begin
          if (entry(stab_reg, 2'(i)) == area_sel) seq_idx_reg <= 2'(i);
        end
      end
    end
  end

  // *****************************************************************
  // output state machine
  // *****************************************************************
  logic any_fault;
  logic trip;
  assign any_fault = ext_fault || ref_fault_reg || seq_fault_reg;
  // a hit in the muted area counts only when muting is not active
  assign trip = any_fault || zone_hit || (mute_area_hit && !mu_muted);

  sofc_state_t state_reg;
  sofc_state_t state_next;
  logic        go_on;
  always_comb begin
    state_next = state_reg;
    go_on      = 1'b0;
    unique case (state_reg)
      SOFC_ST_START: begin
        if (trip) go_on = 1'b0;
        else if (cfg_ilock || !cfg_auto) go_on = reset_edge;
        else go_on = 1'b1;
      end
      SOFC_ST_ON: go_on = !trip;
      SOFC_ST_TRIP: begin
        if (trip) go_on = 1'b0;
        else if (cfg_auto) go_on = 1'b1;
        else go_on = reset_edge;
      end
      default: go_on = 1'b0;
    endcase
    if (state_reg == SOFC_ST_ON && trip) state_next = SOFC_ST_TRIP;
    else if (go_on) state_next = SOFC_ST_ON;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= SOFC_ST_START;
      safety_switch_output <= 1'b0;
      muted_out            <= 1'b0;
      fault_out            <= 1'b0;
    end else begin
      state_reg            <= state_next;
      safety_switch_output <= (state_next == SOFC_ST_ON);
      muted_out            <= mu_muted;
      fault_out            <= any_fault;
    end
  end

  // *****************************************************************
  // trip counter
  // *****************************************************************
  logic trip_evt;
  assign trip_evt = (state_reg == SOFC_ST_ON) && trip;
  always_ff @(posedge aclk) begin
    if (!aresetn) trips_reg <= 32'h0000_0000;
    // a trip in the cycle of the clearing write is still counted
    else if (wr_hit(`SOFC_TRIPS_OFF)) trips_reg <= {31'h0, trip_evt};
    else if (trip_evt && trips_reg != 32'hFFFF_FFFF)
      trips_reg <= trips_reg + 32'h0000_0001;
  end

  // *****************************************************************
  // read decode
  // *****************************************************************
  logic [31:0] status;
  assign status = {21'h00_0000, mu_state, state_reg, ext_fault, seq_fault_reg,
                   ref_fault_reg, mu_ovr, mu_muted, safety_switch_output};

  always_comb begin
    bus.rd_ok   = 1'b1;
    bus.rd_data = 32'h0000_0000;
    unique case (bus.rd_addr)
      `SOFC_CTRL_OFF:  bus.rd_data = ctrl_reg;
      `SOFC_MINT_OFF:  bus.rd_data = mint_reg;
      `SOFC_MMAX_OFF:  bus.rd_data = mmax_reg;
      `SOFC_OVRP_OFF:  bus.rd_data = ovrp_reg;
      `SOFC_RTOL_OFF:  bus.rd_data = rtol_reg;
      `SOFC_STAB_OFF:  bus.rd_data = stab_reg;
      `SOFC_STAT_OFF:  bus.rd_data = status;
      `SOFC_TRIPS_OFF: bus.rd_data = trips_reg;
      default:         bus.rd_ok   = 1'b0;
    endcase
  end

  always_comb begin
    unique case (bus.wr_addr)
      `SOFC_CTRL_OFF, `SOFC_MINT_OFF, `SOFC_MMAX_OFF, `SOFC_OVRP_OFF,
      `SOFC_RTOL_OFF, `SOFC_STAB_OFF, `SOFC_TRIPS_OFF: bus.wr_ok = 1'b1;
      default: bus.wr_ok = 1'b0;
    endcase
  end

  // protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};
endmodule : sofc_core
`default_nettype wire

// ### sofc_core_chk.sv
// sofc_core_chk.sv: port assertions for the safety output block
// assumes: bound into sofc_core, one clock domain
`timescale 1ns/1ns
`default_nettype none
module sofc_core_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic zone_hit,
  input wire logic mute_area_hit,
  input wire logic ext_fault,
  input wire logic safety_switch_output,
  input wire logic muted_out,
  input wire logic fault_out
);
  // *****
  // output checks
  // *****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_off: assert property ($rose(aresetn) |-> !safety_switch_output)
    else $error("output on after reset");
  a_zone_trip: assert property (zone_hit |-> ##[1:2] !safety_switch_output)
    else $error("zone hit kept output on");
  a_zone_hold: assert property (zone_hit [*3] |-> !safety_switch_output)
    else $error("output on inside zone");
  a_ext_off: assert property (ext_fault |-> ##[1:2] !safety_switch_output)
    else $error("fault kept output on");
  a_fault_flag: assert property (ext_fault |-> ##[1:2] fault_out)
    else $error("fault not flagged");
  a_fault_hold: assert property (fault_out [*3] |-> !safety_switch_output)
    else $error("output on with fault");
  a_rise_clear: assert property (
    $rose(safety_switch_output) |-> !$past(zone_hit) && !$past(ext_fault))
    else $error("output on with zone busy");
  a_fall_cause: assert property (
    $fell(safety_switch_output) && !$past(zone_hit) && !$past(ext_fault) &&
    !$past(mute_area_hit) |-> ##[0:2] fault_out)
    else $error("output off without cause");
  a_mute_zone: assert property (muted_out && zone_hit |-> ##[1:3] !muted_out)
    else $error("muting survived zone hit");
  c_out_on: cover property ($rose(safety_switch_output));
  c_out_off: cover property ($fell(safety_switch_output));
  c_muted: cover property ($rose(muted_out));
endmodule : sofc_core_chk
bind sofc_core sofc_core_chk u_chk (.aclk, .aresetn, .zone_hit, .mute_area_hit,
  .ext_fault, .safety_switch_output, .muted_out, .fault_out);
`default_nettype wire

// ### sofc_core_tb_top.sv
// sofc_core_tb_top.sv: register-driven tests of the safety output block
// assumes: sofc_core, its checker and the stop model compiled first
`timescale 1ns/1ns
`default_nettype none
module sofc_core_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, zone_hit, mute_area_hit, reset_in, mute_in_a;
  logic mute_in_b, override_in, ext_fault, safety_switch_output, muted_out;
  logic fault_out, machine_run;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_val;
  logic [15:0] ref_displacement;
  logic [3:0]  wstrb, area_sel;
  logic [2:0]  awprot, arprot;
  logic [1:0]  bresp, rresp, rsp;
  int          err_total, samples_checked;
  sofc_core u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .zone_hit, .mute_area_hit, .reset_in,
    .mute_in_a, .mute_in_b, .override_in, .ref_displacement, .area_sel, .ext_fault,
    .safety_switch_output, .muted_out, .fault_out);
  sofc_stop_model u_stop (.aclk, .aresetn, .safety_switch_output, .machine_run);
  // *****
  // tasks
  // *****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_val = rdata;
    rsp = rresp;
  endtask : rd
  task automatic pulse_rst;
    reset_in <= 1'b1;
    cyc(2);
    reset_in <= 1'b0;
    cyc(4);
  endtask : pulse_rst
  // config only loads while the output is off, so force a short trip
  task automatic setc(input logic [31:0] v);
    wr(8'h00, v);
    ext_fault <= 1'b1;
    cyc(3);
    ext_fault <= 1'b0;
    cyc(4);
  endtask : setc
  task automatic rst_dut;
    aresetn <= 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    cyc(1);
  endtask : rst_dut
  task automatic mute_ab;
    mute_in_a <= 1'b1;
    cyc(5);
    mute_in_b <= 1'b1;
    cyc(5);
  endtask : mute_ab
  task automatic close_out;
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  // *****
  // scenarios
  // *****
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, zone_hit, mute_area_hit} = '0;
    {reset_in, mute_in_a, mute_in_b, override_in, ext_fault} = '0;
    {awaddr, wdata, araddr, ref_displacement, area_sel, awprot, arprot} = '0;
    wstrb = 4'hF;
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    chk(safety_switch_output, 1'b0);
    rd(8'h00);
    chk(rd_val, 32'h2);
    rd(8'h40);
    chk(rsp, 2'h2);
    cyc(20);
    chk(safety_switch_output, 1'b0);
    pulse_rst;
    chk(safety_switch_output, 1'b1);
    zone_hit <= 1'b1;
    cyc(4);
    chk(machine_run, 1'b0);
    cyc(20);
    chk(safety_switch_output, 1'b0);
    zone_hit <= 1'b0;
    cyc(20);
    chk(safety_switch_output, 1'b0);
    pulse_rst;
    chk(safety_switch_output, 1'b1);
    wr(8'h00, 32'h1);
    zone_hit <= 1'b1;
    cyc(4);
    chk(safety_switch_output, 1'b0);
    zone_hit <= 1'b0;
    cyc(4);
    chk(safety_switch_output, 1'b1);
    rst_dut;
    cyc(20);
    chk(safety_switch_output, 1'b0);
    zone_hit <= 1'b1;
    rst_dut;
    wr(8'h00, 32'h1);
    cyc(20);
    chk(safety_switch_output, 1'b0);
    zone_hit <= 1'b0;
    cyc(4);
    chk(safety_switch_output, 1'b1);
    wr(8'h10, 32'h64);
    chk(rsp, 2'h0);
    ref_displacement <= 16'h0064;
    setc(32'h9);
    chk(safety_switch_output, 1'b1);
    ref_displacement <= 16'h0065;
    cyc(4);
    chk(safety_switch_output, 1'b0);
    chk(fault_out, 1'b1);
    ref_displacement <= 16'h0000;
    pulse_rst;
    chk(safety_switch_output, 1'b1);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h2);
    setc(32'h5);
    mute_in_b <= 1'b1;
    cyc(5);
    mute_in_a <= 1'b1;
    cyc(5);
    chk(muted_out, 1'b0);
    override_in <= 1'b1;
    cyc(5);
    chk(muted_out, 1'b1);
    override_in <= 1'b0;
    cyc(1000);
    chk(muted_out, 1'b0);
    {mute_in_a, mute_in_b} <= 2'h0;
    cyc(5);
    mute_in_a <= 1'b1;
    cyc(1250);
    mute_in_b <= 1'b1;
    cyc(5);
    chk(muted_out, 1'b0);
    {mute_in_a, mute_in_b} <= 2'h0;
    cyc(5);
    mute_ab;
    chk(muted_out, 1'b1);
    mute_area_hit <= 1'b1;
    cyc(5);
    chk(safety_switch_output, 1'b1);
    zone_hit <= 1'b1;
    cyc(5);
    chk({muted_out, safety_switch_output}, 2'h0);
    {zone_hit, mute_area_hit, mute_in_a, mute_in_b} <= 4'h0;
    cyc(5);
    mute_ab;
    cyc(1000);
    chk(muted_out, 1'b0);
    {mute_in_a, mute_in_b} <= 2'h0;
    setc(32'h25);
    mute_in_b <= 1'b1;
    cyc(5);
    mute_in_a <= 1'b1;
    cyc(5);
    chk(muted_out, 1'b1);
    {mute_in_a, mute_in_b} <= 2'h0;
    setc(32'h11);
    area_sel <= 4'h1;
    cyc(4);
    chk(safety_switch_output, 1'b1);
    area_sel <= 4'h3;
    cyc(4);
    chk(safety_switch_output, 1'b0);
    rd(8'h18);
    chk(rd_val, 32'h90);
    close_out();
  end
endmodule : sofc_core_tb_top
`default_nettype wire

// ### sofc_mute.sv
// sofc_mute.sv: muting sequence, interval, duration and override timing
// assumes: tick is a one-cycle pulse per time unit, limits in the same unit
`timescale 1ns/1ns
`default_nettype none
module sofc_mute import sofc_pkg::*; #(
  parameter int TW = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          tick,
  input  wire logic          enable,
  input  wire logic          order_ba,
  input  wire logic          in_a,
  input  wire logic          in_b,
  input  wire logic          ovr_req,
  input  wire logic          abort,
  input  wire logic [TW-1:0] max_int,
  input  wire logic [TW-1:0] max_mute,
  input  wire logic [TW-1:0] ovr_per,
  output var  logic          muted,
  output var  logic          ovr_active,
  output var  sofc_mute_t    state
);
  logic [TW-1:0] cnt_reg;
  logic          ovr_prev_reg;
  logic          first_in;
  logic          second_in;
  assign first_in  = order_ba ? in_b : in_a;
  assign second_in = order_ba ? in_a : in_b;
  assign muted      = (state == SOFC_MU_MUTED) || (state == SOFC_MU_OVR);
  assign ovr_active = (state == SOFC_MU_OVR);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SOFC_MU_IDLE; cnt_reg <= '0; ovr_prev_reg <= 1'b0;
    end else begin
      ovr_prev_reg <= ovr_req;
      if (tick && cnt_reg != '1) cnt_reg <= cnt_reg + 1'b1;
      unique case (state)
        SOFC_MU_IDLE: begin
          cnt_reg <= '0;
          if (!enable || abort) state <= SOFC_MU_IDLE;
          else if (second_in) state <= SOFC_MU_BLOCK;
          else if (first_in) state <= SOFC_MU_FIRST;
        end
        SOFC_MU_FIRST: begin
          if (!enable || abort) state <= SOFC_MU_BLOCK;
          else if (cnt_reg > max_int) state <= SOFC_MU_BLOCK;
          else if (!first_in) state <= SOFC_MU_IDLE;
          else if (second_in) begin
            state <= SOFC_MU_MUTED; cnt_reg <= '0;
          end
        end
        SOFC_MU_MUTED: begin
          if (abort || !enable) state <= SOFC_MU_BLOCK;
          else if (cnt_reg > max_mute) state <= SOFC_MU_BLOCK;
          else if (!in_a && !in_b) state <= SOFC_MU_IDLE;
        end
        SOFC_MU_OVR: begin
          if (abort || !enable) state <= SOFC_MU_BLOCK;
          else if (cnt_reg > ovr_per) state <= SOFC_MU_BLOCK;
          else if (!in_a && !in_b) state <= SOFC_MU_IDLE;
        end
        SOFC_MU_BLOCK: begin
          cnt_reg <= '0;
          // override needs a fresh request edge, not a held level
          if (enable && !abort && ovr_req && !ovr_prev_reg && (in_a || in_b))
            state <= SOFC_MU_OVR;
          else if (!in_a && !in_b) state <= SOFC_MU_IDLE;
        end
        default: state <= SOFC_MU_BLOCK;
      endcase
    end
  end
endmodule : sofc_mute
`default_nettype wire

// ### sofc_pkg.sv
// sofc_pkg.sv: types shared by the safety output block
// assumes: sofc_regs.svh holds the numbers
package sofc_pkg;
  typedef enum logic [1:0] {
    SOFC_ST_START = 2'b00,
    SOFC_ST_ON    = 2'b01,
    SOFC_ST_TRIP  = 2'b10
  } sofc_state_t;
  typedef enum logic [2:0] {
    SOFC_MU_IDLE  = 3'b000,
    SOFC_MU_FIRST = 3'b001,
    SOFC_MU_MUTED = 3'b010,
    SOFC_MU_OVR   = 3'b011,
    SOFC_MU_BLOCK = 3'b100
  } sofc_mute_t;
endpackage : sofc_pkg

// ### sofc_regs.svh
// sofc_regs.svh: register offsets, field positions, reset values, timing counts
// assumes: included by the slave and core modules of the safety output block
`ifndef SOFC_REGS_SVH
`define SOFC_REGS_SVH
`define SOFC_CLK_NS          4
`define SOFC_TICK_NS         1000
`define SOFC_TICK_CYC        (`SOFC_TICK_NS / `SOFC_CLK_NS)
`define SOFC_CTRL_OFF        8'h00
`define SOFC_MINT_OFF        8'h04
`define SOFC_MMAX_OFF        8'h08
`define SOFC_OVRP_OFF        8'h0C
`define SOFC_RTOL_OFF        8'h10
`define SOFC_STAB_OFF        8'h14
`define SOFC_STAT_OFF        8'h18
`define SOFC_TRIPS_OFF       8'h1C
`define SOFC_CTRL_AUTO       0
`define SOFC_CTRL_ILOCK      1
`define SOFC_CTRL_MUTE       2
`define SOFC_CTRL_REF        3
`define SOFC_CTRL_SEQ        4
`define SOFC_CTRL_ORDER      5
`define SOFC_CTRL_RST        32'h0000_0002
`define SOFC_MINT_RST        32'h0000_0BB8
`define SOFC_MMAX_RST        32'h0000_EA60
`define SOFC_OVRP_RST        32'h0000_2710
`define SOFC_RTOL_RST        32'h0000_0064
`define SOFC_STAB_RST        32'h0000_3210
`define SOFC_RESP_OKAY       2'h0
`define SOFC_RESP_SLVERR     2'h2
`endif

// ### sofc_stop_model.sv
// sofc_stop_model.sv: machine stop circuit fed by the safety output
// assumes: one clock, machine halts one cycle after the output drops
`timescale 1ns/1ns
`default_nettype none
module sofc_stop_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic safety_switch_output,
  output var  logic machine_run
);
  // *****
  // run contactor
  // *****
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      machine_run <= 1'b0;
    end else begin
      machine_run <= safety_switch_output;
    end
  end
endmodule : sofc_stop_model
`default_nettype wire
